// ---- design/dpdcr_pkg.sv ----
/*
 * constants, field layout and register map of the divider configuration
 * bank and of the controller that programs it over the three-wire link.
 * assumes nothing of its surroundings.
 */
package dpdcr_pkg;
  // ***************************************************
  // serial word and addresses
  // ***************************************************
  localparam int WORD_W = 32;
  localparam int ADDR_W = 5;
  localparam logic [4:0] A_R12 = 5'h0C;
  localparam logic [4:0] A_R26 = 5'h1A;
  localparam logic [4:0] A_R27 = 5'h1B;
  localparam logic [4:0] A_R28 = 5'h1C;
  localparam logic [4:0] A_R29 = 5'h1D;
  localparam logic [4:0] A_R30 = 5'h1E;
  localparam logic [4:0] A_R31 = 5'h1F;
  localparam logic [4:0] A_RSV9 = 5'h09;
  localparam logic [4:0] A_RSV_LO = 5'h11;
  localparam logic [4:0] A_RSV_HI = 5'h17;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int F1R_LSB = 6;
  localparam int F1R_W = 14;
  localparam int CP1_TRI = 5;
  localparam int F2R_LSB = 20;
  localparam int F2R_W = 12;
  localparam int F1N_LSB = 6;
  localparam int F1N_W = 14;
  localparam int OSC_LSB = 24;
  localparam int OSC_W = 3;
  localparam int FAST_BIT = 23;
  localparam int NCAL_LSB = 5;
  localparam int NCAL_W = 18;
  localparam int PRE_LSB = 24;
  localparam int PRE_W = 3;
  localparam int N2_LSB = 5;
  localparam int N2_W = 18;
  localparam int RBLE_BIT = 21;
  localparam int RBA_LSB = 16;
  localparam int LOCK_BIT = 5;
  localparam int DBL_BIT = 29;
  localparam logic [2:0] OSC_RSV = 3'h3;
  localparam logic [2:0] OSC_MAX = 3'h4;
  // ***************************************************
  // counts and controller map
  // ***************************************************
  localparam int CAL_W = 16;
  localparam int CAL_CYCLES_DEF = 256;
  localparam int HALF_DIV_DEF = 4;
  localparam int TICK_W = 16;
  localparam logic [3:0] H_DATA = 4'h0;
  localparam logic [3:0] H_CTRL = 4'h4;
  localparam logic [3:0] H_STAT = 4'h8;
  localparam logic [3:0] H_RB = 4'hC;
endpackage

// ---- design/dpdcr_if.sv ----
/*
 * three-wire programming link between controller and device.
 * assumes both ends share one clock; all wires are plain levels.
 */
`timescale 1ns/100ps
`default_nettype none
interface dpdcr_if;
  logic sclk;
  logic sdata;
  logic le;
  logic rdata;
  modport dev (input sclk, input sdata, input le, output rdata);
  modport host (output sclk, output sdata, output le, input rdata);
endinterface
`default_nettype wire

// ---- design/dpdcr_tick.sv ----
/*
 * enable pulse divider: one pulse every DIV clocks.
 * assumes DIV is at least 1.
 */
`timescale 1ns/100ps
`default_nettype none
module dpdcr_tick import dpdcr_pkg::*; #(
  parameter int DIV = HALF_DIV_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // enable pulse
  output logic tick
);
  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } dpdcr_tick_st_t;
  dpdcr_tick_st_t q, d;

  // count up and wrap at the divide value
  always_comb begin
    d = q;
    d.tick = (q.cnt == TICK_W'(DIV - 1));
    d.cnt = d.tick ? '0 : q.cnt + 1'b1;
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule
`default_nettype wire

// ---- design/dpdcr_host.sv ----
/*
 * controller end: takes words from software over an ahb-lite slave and
 * sends them over the three-wire link, optionally reading a word back.
 * assumes a single ahb master, word transfers only.
 */
`timescale 1ns/100ps
`default_nettype none
module dpdcr_host import dpdcr_pkg::*; #(
  parameter int HALF_DIV = HALF_DIV_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // link
  dpdcr_if.host bus
);
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_LATCH, S_GAP} dpdcr_hst_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic rdy;
    logic av;
    logic aw;
    logic [3:0] aa;
    logic [31:0] data;
    logic [31:0] sh;
    logic [31:0] rb;
    dpdcr_hst_t st;
    logic [4:0] cnt;
    logic sclk;
    logic le;
    logic sdo;
    logic rd;
    logic ph2;
    logic busy;
    logic err;
    logic dbl;
  } dpdcr_host_st_t;
  dpdcr_host_st_t q, d;
  logic tick;
  logic go;
  logic bad;
  logic [4:0] wa;

  dpdcr_tick #(.DIV(HALF_DIV)) u_tick (
    .clock(clock),
    .reset(reset),
    .tick(tick)
  );

  // bus decode, command check and serial sequencing
  always_comb begin
    d = q;
    go = 1'b0;
    bad = 1'b0;
    wa = q.data[ADDR_W-1:0];
    d.rdy = 1'b1;
    // address phase capture, read data ready for the data phase
    d.av = hsel & htrans[1] & hready;
    d.aw = hwrite;
    d.aa = haddr[3:0];
    case (haddr[3:0])
      H_DATA: d.hrdata = q.data;
      H_STAT: d.hrdata = {30'h0, q.err, q.busy};
      H_RB: d.hrdata = q.rb;
      default: d.hrdata = 32'h0;
    endcase
    // reserved or invalid codes are refused
    case (wa)
      A_R27: bad = (q.data[F1R_LSB +: F1R_W] == '0);
      A_R28: bad = (q.data[F2R_LSB +: F2R_W] == '0) |
        (q.data[F1N_LSB +: F1N_W] == '0) |
        ((q.data[F2R_LSB +: F2R_W] == F2R_W'(1)) & ~q.dbl);
      A_R29: bad = (q.data[OSC_LSB +: OSC_W] == OSC_RSV) |
        (q.data[OSC_LSB +: OSC_W] > OSC_MAX) |
        (q.data[NCAL_LSB +: NCAL_W] < NCAL_W'(2));
      A_R30: bad = (q.data[N2_LSB +: N2_W] == '0);
      A_R31: bad = (q.data[RBA_LSB +: ADDR_W] == A_RSV9) |
        ((q.data[RBA_LSB +: ADDR_W] >= A_RSV_LO) &
         (q.data[RBA_LSB +: ADDR_W] <= A_RSV_HI));
      default: bad = 1'b0;
    endcase
    // fast flag goes out as software wrote it, a calibration divider below two is refused
    if (q.av & q.aw) begin
      case (q.aa)
        H_DATA: if (!q.busy) d.data = hwdata;
        H_CTRL: go = ~q.busy & (hwdata[0] | hwdata[1]);
        H_STAT: if (hwdata[1]) d.err = 1'b0;
        default: d.err = d.err;
      endcase
    end
    case (q.st)
      S_IDLE: begin
        if (go & bad) begin
          d.err = 1'b1;
        end else if (go) begin
          d.rd = hwdata[1];
          d.ph2 = 1'b0;
          d.sh = q.data;
          d.sdo = q.data[31];
          d.cnt = '0;
          d.sclk = 1'b0;
          d.le = 1'b0;
          d.busy = 1'b1;
          d.st = S_SHIFT;
          if (wa == A_R26) d.dbl = q.data[DBL_BIT];
        end
      end
      S_SHIFT: if (tick) begin
        if (!q.sclk) begin
          d.sclk = 1'b1;
          if (q.ph2) d.rb = {q.rb[30:0], bus.rdata};
        end else begin
          d.sclk = 1'b0;
          d.sh = {q.sh[30:0], 1'b0};
          d.sdo = q.sh[30];
          d.cnt = q.cnt + 1'b1;
          if (q.cnt == 5'h1F) d.st = S_LATCH;
        end
      end
      S_LATCH: if (tick) begin
        d.le = 1'b1;
        d.st = S_GAP;
      end
      S_GAP: if (tick) begin
        if (q.rd & ~q.ph2) begin
          // second pass clocks the word out with le held at its level
          d.ph2 = 1'b1;
          d.sh = q.data;
          d.sdo = q.data[31];
          d.cnt = '0;
          d.le = q.data[RBLE_BIT];
          d.st = S_SHIFT;
        end else begin
          d.busy = 1'b0;
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
    if (go & bad) d.err = 1'b1;
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.le <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.rdy;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign bus.sclk = q.sclk;
  assign bus.le = q.le;
  assign bus.sdata = q.sdo;
endmodule
`default_nettype wire

// ---- design/dpdcr_device.sv ----
/*
 * device end: upper divider configuration bank (words 26 to 31) behind
 * the three-wire link, with readback, write protect and calibration
 * start. assumes link pins are synchronous to clock and that sclk
 * holds each level for at least two clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module dpdcr_device import dpdcr_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  dpdcr_if.dev bus,
  // mode strap
  input wire logic internal_osc_mode,
  // first loop
  output logic [F1R_W-1:0] first_loop_reference_divider,
  output logic first_loop_pump_output_pin_oe,
  output logic [F1N_W-1:0] first_loop_feedback_divider,
  // second loop
  output logic [F2R_W-1:0] second_loop_reference_divider,
  output logic second_loop_reference_doubler_on,
  output logic [OSC_W-1:0] oscillator_input_range,
  output logic second_loop_fast_detector_flag,
  output logic [NCAL_W-1:0] calibration_feedback_divider,
  output logic [N2_W-1:0] second_loop_feedback_divider,
  output logic [3:0] prescaler_ratio,
  output logic [N2_W-1:0] active_feedback_divider,
  // calibration and status
  output logic calibration_start,
  output logic sync_event,
  output logic calibration_busy,
  output logic register_write_protect,
  output logic settings_valid
);
  typedef struct packed {
    logic sclk;
    logic le;
    logic [31:0] sin;
    logic [31:0] sout;
    logic [31:0] r26;
    logic [31:0] r27;
    logic [31:0] r28;
    logic [31:0] r29;
    logic [31:0] r30;
    logic [31:0] r31;
    logic [CAL_W-1:0] cal;
    logic cal_start;
    logic sync;
    logic busy;
    logic [N2_W-1:0] n_act;
    logic [3:0] pre;
    logic ok;
  } dpdcr_dev_st_t;
  dpdcr_dev_st_t q, d;
  logic rise;
  logic latch;
  logic wr_ok;
  logic [4:0] addr;
  logic [4:0] rba;

  // ***************************************************
  // link, register writes, readback, calibration
  // ***************************************************
  always_comb begin
    d = q;
    d.cal_start = 1'b0;
    d.sync = 1'b0;
    d.sclk = bus.sclk;
    d.le = bus.le;
    rise = bus.sclk & ~q.sclk;
    latch = bus.le & ~q.le;
    addr = q.sin[ADDR_W-1:0];
    // locked words below 31 are refused, word 31 is always taken
    wr_ok = (addr == A_R31) | ~q.r31[LOCK_BIT];
    // data shifts in msb first while the latch pin is low
    if (rise & ~bus.le) d.sin = {q.sin[30:0], bus.sdata};
    // readback clocks out only at the programmed latch level
    if (rise & (bus.le == q.r31[RBLE_BIT])) begin
      d.sout = {q.sout[30:0], 1'b0};
    end
    if (latch & wr_ok) begin
      case (addr)
        A_R26: d.r26 = q.sin;
        A_R27: d.r27 = q.sin;
        A_R28: d.r28 = q.sin;
        A_R29: d.r29 = q.sin;
        A_R30: d.r30 = q.sin;
        A_R31: d.r31 = q.sin;
        default: d.r26 = d.r26;
      endcase
    end
    rba = d.r31[RBA_LSB +: ADDR_W];
    // each latch reloads the readback word, lock or not
    if (latch) begin
      case (rba)
        A_R12: d.sout = {11'h0, rba, 16'h0};
        A_R26: d.sout = d.r26;
        A_R27: d.sout = d.r27;
        A_R28: d.sout = d.r28;
        A_R29: d.sout = d.r29;
        A_R30: d.sout = d.r30;
        A_R31: d.sout = d.r31;
        default: d.sout = 32'h0;
      endcase
    end
    // feedback word written in internal mode starts calibration
    if (latch & wr_ok & (addr == A_R30) & internal_osc_mode) begin
      d.cal = CAL_W'(CAL_CYCLES);
      d.cal_start = 1'b1;
      d.sync = 1'b1;
    end else if (q.cal != '0) begin
      d.cal = q.cal - 1'b1;
    end
    d.busy = (d.cal != '0);
    // calibration divider stands in for the feedback divider
    d.n_act = d.busy ? d.r29[NCAL_LSB +: NCAL_W] : d.r30[N2_LSB +: N2_W];
    // prescaler decode
    case (d.r30[PRE_LSB +: PRE_W])
      3'h0: d.pre = 4'h8;
      3'h1, 3'h2: d.pre = 4'h2;
      default: d.pre = {1'b0, d.r30[PRE_LSB +: PRE_W]};
    endcase
    // divider codes in range, zero codes flagged
    d.ok = (d.r27[F1R_LSB +: F1R_W] != '0) &
      (d.r28[F2R_LSB +: F2R_W] != '0) &
      (d.r28[F1N_LSB +: F1N_W] != '0) &
      (d.r29[OSC_LSB +: OSC_W] != OSC_RSV) &
      (d.r29[OSC_LSB +: OSC_W] <= OSC_MAX) &
      (d.r29[NCAL_LSB +: NCAL_W] >= NCAL_W'(2)) &
      (d.r30[N2_LSB +: N2_W] != '0) &
      // divide-by-one feedback only outside internal mode or with
      // a calibration divider above one
      ((d.r30[N2_LSB +: N2_W] != N2_W'(1)) | ~internal_osc_mode |
       (d.r29[NCAL_LSB +: NCAL_W] > NCAL_W'(1)));
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.r26 <= REG_RESET;
      q.r27 <= REG_RESET;
      q.r28 <= REG_RESET;
      q.r29 <= REG_RESET;
      q.r30 <= REG_RESET;
      q.r31 <= REG_RESET;
      q.le <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // field outputs from the stored words, prescaler ratio and active divider from their registered decodes
  assign first_loop_reference_divider = q.r27[F1R_LSB +: F1R_W];
  assign first_loop_pump_output_pin_oe = ~q.r27[CP1_TRI];
  assign first_loop_feedback_divider = q.r28[F1N_LSB +: F1N_W];
  assign second_loop_reference_divider = q.r28[F2R_LSB +: F2R_W];
  assign second_loop_reference_doubler_on = q.r26[DBL_BIT];
  assign oscillator_input_range = q.r29[OSC_LSB +: OSC_W];
  assign second_loop_fast_detector_flag = q.r29[FAST_BIT];
  assign calibration_feedback_divider = q.r29[NCAL_LSB +: NCAL_W];
  assign second_loop_feedback_divider = q.r30[N2_LSB +: N2_W];
  assign prescaler_ratio = q.pre;
  assign active_feedback_divider = q.n_act;
  // status and pulses
  assign calibration_start = q.cal_start;
  assign sync_event = q.sync;
  assign calibration_busy = q.busy;
  assign register_write_protect = q.r31[LOCK_BIT];
  assign settings_valid = q.ok;
  assign bus.rdata = q.sout[31];
endmodule
`default_nettype wire

// ---- verif/dpdcr_asserts.sv ----
/* link checker: timing and framing of the three-wire link.
   assumes it stands beside the link interface, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module dpdcr_asserts #(
  parameter int HALF_DIV = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  input wire logic sclk,
  input wire logic sdata,
  input wire logic le,
  input wire logic rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] hi_q;
  logic [5:0] nb_q;
  logic ev_q;
  // high phase length, rises per frame, recent link event
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hi_q <= 8'h00;
      nb_q <= 6'h00;
      ev_q <= 1'b0;
    end else begin
      hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
      nb_q <= ($rose(le) || $fell(le)) ? 6'h00 : nb_q + {5'h00, $rose(sclk)};
      ev_q <= $rose(sclk) || $rose(le);
    end
  end
  a_sclk_high_len: assert property ($fell(sclk) |-> hi_q == HALF_DIV)
    else $error("sclk high phase length wrong");
  a_sclk_low_min: assert property ($fell(sclk) |=> !sclk)
    else $error("sclk low phase too short");
  a_data_steady: assert property (sclk |-> $stable(sdata))
    else $error("sdata moved while sclk high");
  a_latch_low: assert property ($rose(le) |-> !sclk)
    else $error("latch while sclk high");
  a_latch_hold: assert property ($rose(le) |=> le)
    else $error("latch pulse too short");
  a_frame_bits: assert property ($rose(le) |-> nb_q == 6'h20)
    else $error("frame not 32 bits");
  a_frame_start: assert property ($fell(le) |-> ##[1:16] $rose(sclk))
    else $error("no sclk after frame start");
  a_rb_timing: assert property (
    $changed(rdata) |-> ev_q || $past(ev_q))
    else $error("rdata changed without link event");
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
/* testbench: controller and device joined over the link, run over ahb-lite.
   assumes the package, interface and design modules compile first. */
`timescale 1ns/100ps
`default_nettype none
module testbench import dpdcr_pkg::*; ;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd, st;
  logic internal_osc_mode = 1'b0;
  logic [13:0] first_loop_reference_divider, first_loop_feedback_divider;
  logic [11:0] second_loop_reference_divider;
  logic [2:0] oscillator_input_range;
  logic [17:0] calibration_feedback_divider, second_loop_feedback_divider;
  logic [17:0] active_feedback_divider;
  logic [3:0] prescaler_ratio;
  logic first_loop_pump_output_pin_oe, second_loop_reference_doubler_on;
  logic second_loop_fast_detector_flag, calibration_start, sync_event;
  logic calibration_busy, register_write_protect, settings_valid;
  int n_errors = 0;
  int n_tests = 0;
  int n_cal = 0;
  int c0;
  int n_busy = 0;
  int b0;
  logic [17:0] act_cal;
  logic [17:0] nv;
  logic [3:0] pr;
  // ****
  // clock, instances
  // ****
  always #25 clock = ~clock;
  dpdcr_if u_dpdcr_if ();
  dpdcr_host #(.HALF_DIV(2)) u_dpdcr_host (.clock, .reset, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .bus(u_dpdcr_if));
  dpdcr_device #(.CAL_CYCLES(4)) u_dpdcr_device (.clock, .reset,
    .bus(u_dpdcr_if), .internal_osc_mode, .first_loop_reference_divider,
    .first_loop_pump_output_pin_oe, .first_loop_feedback_divider,
    .second_loop_reference_divider, .second_loop_reference_doubler_on,
    .oscillator_input_range, .second_loop_fast_detector_flag,
    .calibration_feedback_divider, .second_loop_feedback_divider,
    .prescaler_ratio, .active_feedback_divider, .calibration_start,
    .sync_event, .calibration_busy, .register_write_protect, .settings_valid);
  dpdcr_asserts #(.HALF_DIV(2)) u_dpdcr_asserts (.clock(clock), .reset(reset),
    .sclk(u_dpdcr_if.sclk), .sdata(u_dpdcr_if.sdata), .le(u_dpdcr_if.le),
    .rdata(u_dpdcr_if.rdata));
  // counts calibration starts with sync, busy cycles, divider in use
  always @(posedge clock) begin
    if (calibration_start === 1'b1 && sync_event === 1'b1) n_cal++;
    if (calibration_busy === 1'b1) begin
      n_busy++;
      act_cal = active_feedback_divider;
    end
  end
  // ****
  // tasks
  // ****
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single ahb transfer, waits on hready in both phases
  task automatic ahb(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge clock);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clock);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // sends a word, optionally reads back, waits until idle
  task automatic send(input logic [31:0] w, input logic rb);
    ahb(1'b1, H_DATA, w, rd);
    ahb(1'b1, H_CTRL, {30'h0, rb, ~rb}, rd);
    do begin
      ahb(1'b0, H_STAT, 32'h0, st);
    end while (st[0] !== 1'b0);
    if (rb) ahb(1'b0, H_RB, 32'h0, rd);
  endtask
  // checks the error flag is set, then clears it
  task automatic refused;
    ahb(1'b0, H_STAT, 32'h0, st);
    check("err", {31'h0, st[1]}, 32'h1);
    ahb(1'b1, H_STAT, 32'h2, st);
  endtask
  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    finish_test();
  end
  // ****
  // test sequence
  // ****
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check("valid", settings_valid, 32'h0);
    check("oe", first_loop_pump_output_pin_oe, 32'h1);
    check("lock", register_write_protect, 32'h0);
    send(32'h2000_0000 | A_R26, 1'b0);
    check("dbl", second_loop_reference_doubler_on, 32'h1);
    ahb(1'b0, H_DATA, 32'h0, rd);
    check("data", rd, 32'h2000_0000 | A_R26);
    send((32'h3FFF << F1R_LSB) | 32'h20 | A_R27, 1'b0);
    check("r1", first_loop_reference_divider, 32'h3FFF);
    check("oe", first_loop_pump_output_pin_oe, 32'h0);
    send((32'h1 << F1R_LSB) | A_R27, 1'b0);
    check("r1", first_loop_reference_divider, 32'h1);
    check("oe", first_loop_pump_output_pin_oe, 32'h1);
    send((32'h1 << F2R_LSB) | (32'h3FFF << F1N_LSB) | A_R28, 1'b0);
    check("r2", second_loop_reference_divider, 32'h1);
    check("n1", first_loop_feedback_divider, 32'h3FFF);
    send((32'hFFF << F2R_LSB) | (32'h1 << F1N_LSB) | A_R28, 1'b0);
    check("r2", second_loop_reference_divider, 32'hFFF);
    check("n1", first_loop_feedback_divider, 32'h1);
    send((32'h1 << F1N_LSB) | A_R28, 1'b0);
    refused();
    check("r2", second_loop_reference_divider, 32'hFFF);
    for (int i = 0; i < 4; i++) begin
      nv = (i == 3) ? 18'h3FFFF : 18'(i + 2);
      pr = (i == 3) ? 4'h4 : 4'(i);
      send((32'(pr) << OSC_LSB) | (32'(i % 2) << FAST_BIT)
           | (32'(nv) << NCAL_LSB) | A_R29, 1'b0);
      check("osc", oscillator_input_range, 32'(pr));
      check("fast", second_loop_fast_detector_flag, 32'(i % 2));
      check("ncal", calibration_feedback_divider, 32'(nv));
    end
    for (int p = 0; p < 8; p++) begin
      nv = (p == 7) ? 18'h3FFFF : 18'(p + 2);
      pr = (p == 0) ? 4'h8 : (p < 3) ? 4'h2 : 4'(p);
      internal_osc_mode <= p[0];
      send((32'h1 << OSC_LSB) | (32'(nv) << NCAL_LSB) | A_R29, 1'b0);
      c0 = n_cal;
      b0 = n_busy;
      send((32'(p) << PRE_LSB) | (32'(nv) << N2_LSB) | A_R30, 1'b0);
      repeat (8) @(posedge clock);
      check("cal", 32'(n_cal - c0), 32'(p % 2));
      check("busy", 32'(n_busy - b0), 32'(4 * (p % 2)));
      check("act", active_feedback_divider, 32'(nv));
      check("pre", prescaler_ratio, 32'(pr));
      check("n2", second_loop_feedback_divider, 32'(nv));
    end
    // zero-delay style setup: feedback divide by one, calibration by two
    send((32'h1 << OSC_LSB) | (32'h2 << NCAL_LSB) | A_R29, 1'b0);
    b0 = n_busy;
    send((32'h1 << N2_LSB) | A_R30, 1'b0);
    repeat (8) @(posedge clock);
    check("busy", 32'(n_busy - b0), 32'h4);
    check("ncal act", act_cal, 32'h2);
    check("n2 act", active_feedback_divider, 32'h1);
    check("valid", settings_valid, 32'h1);
    send(32'h0020_0000 | (32'(A_R12) << RBA_LSB) | A_R31, 1'b1);
    check("rb12", rd, 32'(A_R12) << RBA_LSB);
    send((32'(A_R27) << RBA_LSB) | A_R31, 1'b1);
    check("rb27", rd, (32'h1 << F1R_LSB) | A_R27);
    send((32'(A_RSV9) << RBA_LSB) | A_R31, 1'b0);
    refused();
    send(32'h0020_0020 | (32'(A_R27) << RBA_LSB) | A_R31, 1'b0);
    check("lock", register_write_protect, 32'h1);
    send((32'h5 << F1R_LSB) | A_R27, 1'b0);
    check("r1", first_loop_reference_divider, 32'h1);
    send(32'h0020_0020 | (32'(A_R27) << RBA_LSB) | A_R31, 1'b1);
    check("rblk", rd, (32'h1 << F1R_LSB) | A_R27);
    send(32'h0020_0020 | (32'(A_R31) << RBA_LSB) | A_R31, 1'b1);
    check("rb31", rd & 32'h20, 32'h20);
    send(A_R31, 1'b0);
    check("lock", register_write_protect, 32'h0);
    send((32'h5 << F1R_LSB) | A_R27, 1'b0);
    check("r1", first_loop_reference_divider, 32'h5);
    finish_test();
  end
endmodule
`default_nettype wire
